// [verilog/sfpl_map.vh]
// Constants of the serial flash program, lock and erase block.
// Assumes a 100 MHz system clock and a 2-Mbit, 64-Kbyte-sector array.
`ifndef SFPL_MAP_VH
`define SFPL_MAP_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SFPL_OP_WRITE_ENABLE_CMD      8'h06
`define SFPL_OP_PROG      8'h02
`define SFPL_OP_ERASE     8'hDB
`define SFPL_OP_LOCK      8'hE5

// ----------------------------------------------------------------
// Geometry and lock byte layout
// ----------------------------------------------------------------
`define SFPL_ADDR_W       18
`define SFPL_MEM_BYTES    262144
`define SFPL_SECT_HI      17
`define SFPL_SECT_LO      16
`define SFPL_LOCK_WL      0
`define SFPL_LOCK_LD      1
`define SFPL_LOCK_RST     2'b00
`define SFPL_ERASED       8'hFF
`define SFPL_FRAME_DATA   3'd5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFPL_CLK_NS       10
`define SFPL_PROG_NS      1000000
`define SFPL_ERASE_NS     2000000
`define SFPL_DESEL_NS     100

`endif

// [verilog/sfpl_fifo.v]
// Small synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on the same clock.
module sfpl_fifo
#(
   parameter W  = 8,
   parameter D  = 8,
   parameter AW = 3
)
(
   // Clock and reset
   input  wire          clk,
   input  wire          rst_b,
   // Fill side
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   // Drain side
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);

   reg  [W-1:0]  mem_r [0:D-1];
   reg  [AW-1:0] wr_r;
   reg  [AW-1:0] rd_r;
   reg  [AW:0]   cnt_r;
   wire          push;
   wire          pop;

   assign in_ready  = (cnt_r != D[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk)
   begin
      if (push)
         mem_r[wr_r] <= in_data;
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
         if (pop)
            rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
         if (push & !pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & !push)
            cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule // sfpl_fifo

// [verilog/sfpl_flash.v]
// Serial flash core: page program, lock byte write and page erase.
// Assumes the serial pins come from another domain; peek ports are local.
`include "sfpl_map.vh"

module sfpl_flash
#(
   parameter PROG_CYC  = `SFPL_PROG_NS / `SFPL_CLK_NS,
   parameter ERASE_CYC = `SFPL_ERASE_NS / `SFPL_CLK_NS
)
(
   // Clock and reset
   input  wire                    clk,
   input  wire                    rst_b,
   // Serial pins
   input  wire                    cs_b,
   input  wire                    sck,
   input  wire                    sdi,
   // Hardware protection level: 0 none, 1 top quarter, 2 top half, 3 all
   input  wire [1:0]              hw_protect,
   // Status
   output wire                    cycle_active_flag,
   output wire                    write_enable_latch,
   // Array and lock peek
   input  wire [`SFPL_ADDR_W-1:0] peek_addr,
   output reg  [7:0]              peek_data,
   output reg  [7:0]              sector_lock_bits
);

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_PEND = 4'b0010;
   localparam [3:0] ST_WALK = 4'b0100;
   localparam [3:0] ST_WAIT = 4'b1000;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg  [7:0]              mem_r [0:`SFPL_MEM_BYTES-1];
   reg  [7:0]              pb_r  [0:255];
   reg  [255:0]            mask_r;
   reg  [3:0]              wl_r;
   reg  [3:0]              ld_r;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg                     cs_s1;
   reg                     cs_s2;
   reg                     cs_s3;
   reg                     sck_s1;
   reg                     sck_s2;
   reg                     sck_s3;
   reg                     sdi_s1;
   reg                     sdi_s2;
   reg  [1:0]              prot_s1;
   reg  [1:0]              prot_s2;

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cs_s1   <= 1'b1;
         cs_s2   <= 1'b1;
         cs_s3   <= 1'b1;
         sck_s1  <= 1'b0;
         sck_s2  <= 1'b0;
         sck_s3  <= 1'b0;
         sdi_s1  <= 1'b0;
         sdi_s2  <= 1'b0;
         prot_s1 <= 2'b00;
         prot_s2 <= 2'b00;
      end
      else
      begin
         cs_s1   <= cs_b;
         cs_s2   <= cs_s1;
         cs_s3   <= cs_s2;
         sck_s1  <= sck;
         sck_s2  <= sck_s1;
         sck_s3  <= sck_s2;
         sdi_s1  <= sdi;
         sdi_s2  <= sdi_s1;
         prot_s1 <= hw_protect;
         prot_s2 <= prot_s1;
      end
   end

   wire cs_low   = !cs_s2;
   wire cs_rise  = cs_s2 & !cs_s3;
   wire cs_fall  = !cs_s2 & cs_s3;
   wire sck_rise = sck_s2 & !sck_s3 & cs_low;

   // ----------------------------------------------------------------
   // Frame receiver
   // ----------------------------------------------------------------
   reg  [3:0]              st_r;
   reg                     wel_r;
   reg                     wip_r;
   reg  [2:0]              bit_r;
   reg  [2:0]              byte_r;
   reg  [6:0]              shift_r;
   reg  [7:0]              op_r;
   reg  [`SFPL_ADDR_W-1:0] addr_r;
   reg  [7:0]              lbyte_r;
   reg                     ok_r;

   wire       busy      = wip_r;
   wire       byte_done = sck_rise & (bit_r == 3'd7);
   wire [7:0] byte_val  = {shift_r, sdi_s2};
   wire       op_now_pp = (byte_val == `SFPL_OP_PROG);
   wire       first_b   = byte_done & (byte_r == 3'd0);
   wire       clr_mask  = first_b & op_now_pp & !busy;
   wire       load_ptr  = byte_done & (byte_r == 3'd3) & ok_r &
                          (op_r == `SFPL_OP_PROG);
   wire       data_b    = byte_done & (byte_r >= 3'd4);
   wire       push_v    = data_b & ok_r & (op_r == `SFPL_OP_PROG);

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bit_r   <= 3'd0;
         byte_r  <= 3'd0;
         shift_r <= 7'h00;
         op_r    <= 8'h00;
         addr_r  <= {`SFPL_ADDR_W{1'b0}};
         lbyte_r <= 8'h00;
         ok_r    <= 1'b0;
      end
      else if (cs_fall)
      begin
         bit_r  <= 3'd0;
         byte_r <= 3'd0;
      end
      else if (sck_rise)
      begin
         shift_r <= byte_val[6:0];
         bit_r   <= bit_r + 3'd1;
         if (byte_done)
         begin
            if (byte_r != 3'd7)
               byte_r <= byte_r + 3'd1;
            if (byte_r == 3'd0)
            begin
               op_r <= byte_val;
               ok_r <= !busy;
            end
            else if (byte_r <= 3'd3)
               addr_r <= {addr_r[9:0], byte_val};
            else
               lbyte_r <= byte_val;
         end
      end
   end

   // ----------------------------------------------------------------
   // Data FIFO and page buffer
   // ----------------------------------------------------------------
   wire       f_in_ready;
   wire       f_out_valid;
   wire [7:0] f_out_data;
   wire       f_out_ready = (st_r == ST_IDLE) | (st_r == ST_PEND);
   reg  [7:0] ptr_r;
   reg        drop_r;

   sfpl_fifo #(.W(8), .D(8), .AW(3)) u_fifo
   (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (push_v),
      .in_ready  (f_in_ready),
      .in_data   (byte_val),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ptr_r  <= 8'h00;
         mask_r <= 256'd0;
         drop_r <= 1'b0;
      end
      else
      begin
         if (clr_mask)
         begin
            mask_r <= 256'd0;
            drop_r <= 1'b0;
         end
         else if (f_out_valid & f_out_ready)
            mask_r[ptr_r] <= 1'b1;
         if (push_v & !f_in_ready)
            drop_r <= 1'b1;
         if (load_ptr)
            ptr_r <= byte_val;
         else if (f_out_valid & f_out_ready)
            ptr_r <= ptr_r + 8'd1;
      end
   end

   // ----------------------------------------------------------------
   // Decode at select rise
   // ----------------------------------------------------------------
   wire [1:0] sect    = addr_r[`SFPL_SECT_HI:`SFPL_SECT_LO];
   wire       hw_hit  = (prot_s2 == 2'd3) |
                        (prot_s2[1] & sect[1]) |
                        ((prot_s2 == 2'd1) & (sect == 2'd3));

   wire on_byte  = (bit_r == 3'd0);
   wire can_wr   = ok_r & wel_r & !busy & on_byte;
   wire blocked  = hw_hit | wl_r[sect];
   wire go_prog  = cs_rise & can_wr & (op_r == `SFPL_OP_PROG) &
                   (byte_r >= `SFPL_FRAME_DATA) &
                   !blocked & !drop_r;
   wire go_erase = cs_rise & can_wr & (op_r == `SFPL_OP_ERASE) &
                   (byte_r == 3'd4) & !blocked;
   wire go_lock  = cs_rise & can_wr & (op_r == `SFPL_OP_LOCK) &
                   (byte_r == `SFPL_FRAME_DATA) &
                   !ld_r[sect];
   wire go_write_enable_cmd  = cs_rise & on_byte & (byte_r == 3'd1) &
                   (op_r == `SFPL_OP_WRITE_ENABLE_CMD);

   // ----------------------------------------------------------------
   // Lock bits
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wl_r <= {2{`SFPL_LOCK_RST}};
         ld_r <= {2{`SFPL_LOCK_RST}};
      end
      else if (go_lock)
      begin
         wl_r[sect] <= lbyte_r[`SFPL_LOCK_WL];
         ld_r[sect] <= lbyte_r[`SFPL_LOCK_LD];
      end
   end

   // ----------------------------------------------------------------
   // Self-timed cycle engine
   // ----------------------------------------------------------------
   reg         erase_r;
   reg  [7:0]  idx_r;
   reg  [23:0] cnt_r;
   reg  [3:0]  st_nxt;
   wire [23:0] target = erase_r ? ERASE_CYC[23:0] : PROG_CYC[23:0];
   wire [`SFPL_ADDR_W-1:0] waddr = {addr_r[`SFPL_ADDR_W-1:8], idx_r};

   always @*
   begin
      case (st_r)
         ST_IDLE: st_nxt = (go_prog | go_erase) ? ST_PEND : ST_IDLE;
         ST_PEND: st_nxt = f_out_valid ? ST_PEND : ST_WALK;
         ST_WALK: st_nxt = (idx_r == 8'hFF) ? ST_WAIT : ST_WALK;
         ST_WAIT: st_nxt = (cnt_r >= target) ? ST_IDLE : ST_WAIT;
         default: st_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk)
   begin
      if (f_out_valid & f_out_ready)
         pb_r[ptr_r] <= f_out_data;
      if (st_r == ST_WALK)
      begin
         if (erase_r)
            mem_r[waddr] <= `SFPL_ERASED;
         else if (mask_r[idx_r])
            mem_r[waddr] <= mem_r[waddr] & pb_r[idx_r];
      end
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r    <= ST_IDLE;
         wip_r   <= 1'b0;
         wel_r   <= 1'b0;
         erase_r <= 1'b0;
         idx_r   <= 8'h00;
         cnt_r   <= 24'd0;
      end
      else
      begin
         st_r <= st_nxt;
         if (st_r != ST_IDLE)
            cnt_r <= cnt_r + 24'd1;
         if (st_r == ST_WALK)
            idx_r <= idx_r + 8'd1;
         if (go_prog | go_erase)
         begin
            wip_r   <= 1'b1;
            erase_r <= go_erase;
            idx_r   <= 8'h00;
            cnt_r   <= 24'd1;
         end
         else if ((st_r == ST_WAIT) & (st_nxt == ST_IDLE))
            wip_r <= 1'b0;
         if (go_write_enable_cmd)
            wel_r <= 1'b1;
         else if (go_lock)
            wel_r <= 1'b0;
         else if ((st_r == ST_WALK) & (idx_r == 8'hFF))
            wel_r <= 1'b0;
      end
   end

   assign cycle_active_flag  = wip_r;
   assign write_enable_latch = wel_r;

   // ----------------------------------------------------------------
   // Peek ports
   // ----------------------------------------------------------------
   wire [1:0] psect = peek_addr[`SFPL_SECT_HI:`SFPL_SECT_LO];

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         peek_data        <= 8'h00;
         sector_lock_bits <= 8'h00;
      end
      else
      begin
         peek_data        <= mem_r[peek_addr];
         sector_lock_bits <= {6'b00_0000, ld_r[psect], wl_r[psect]};
      end
   end

endmodule // sfpl_flash

// [test/sfpl_host.sv]
// Host model that frames instructions on the serial pins.
// Assumes the bench fills the byte queue and then calls send.
module sfpl_host
(
   // Serial pins
   output logic cs_b,
   output logic sck,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] q[$];

   initial
   begin
      cs_b = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end

   task automatic bit_out(input logic b, input real hp);
      sdi = b;
      #hp sck = 1'b1;
      #hp sck = 1'b0;
   endtask

   // Whole bytes MSB first, then extra bits to break the byte boundary
   task automatic send(input int extra, input real hp);
      logic [7:0] b;
      cs_b = 1'b0;
      #hp;
      while (q.size() > 0)
      begin
         b = q.pop_front();
         for (int i = 7; i >= 0; i--)
            bit_out(b[i], hp);
      end
      for (int i = 0; i < extra; i++)
         bit_out(1'b1, hp);
      #hp cs_b = 1'b1;
      sdi = ~sdi;
      #300;
   endtask
endmodule // sfpl_host

// [test/sfpl_flash_asserts.sv]
// Checker for the serial flash program, lock and erase core.
// Assumes it is bound to the core and sees only its ports.
`include "sfpl_map.vh"
module sfpl_flash_asserts
#(
   parameter PROG_CYC  = 400,
   parameter ERASE_CYC = 600
)
(
   // Clock and reset
   input wire                    clk,
   input wire                    rst_b,
   // Serial pins and protection
   input wire                    cs_b,
   input wire                    sck,
   input wire                    sdi,
   input wire [1:0]              hw_protect,
   // Status and peek
   input wire                    cycle_active_flag,
   input wire                    write_enable_latch,
   input wire [`SFPL_ADDR_W-1:0] peek_addr,
   input wire [7:0]              peek_data,
   input wire [7:0]              sector_lock_bits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [31:0] busy_cnt_r;
   logic        wel_low_r;

   // Counts the cycles of each busy span
   always @(posedge clk or negedge rst_b)
      if (!rst_b)
         busy_cnt_r <= 32'h0000_0000;
      else if (cycle_active_flag)
         busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
      else
         busy_cnt_r <= 32'h0000_0000;

   // Notes whether the latch was seen low during the current busy span
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wel_low_r <= 1'b0;
      else if (!cycle_active_flag)
         wel_low_r <= 1'b0;
      else if (!write_enable_latch)
         wel_low_r <= 1'b1;
   end

   property p_busy_cs;
      $rose(cycle_active_flag) |-> cs_b && $past(cs_b);
   endproperty
   a_busy_cs: assert property (p_busy_cs)
      else $error("busy started inside a frame");
   property p_wel_cs;
      $rose(write_enable_latch) |-> cs_b;
   endproperty
   a_wel_cs: assert property (p_wel_cs)
      else $error("latch set inside a frame");
   property p_busy_wel;
      $rose(cycle_active_flag) |-> $past(write_enable_latch);
   endproperty
   a_busy_wel: assert property (p_busy_wel)
      else $error("cycle started without latch");
   property p_wel_end;
      $fell(cycle_active_flag) |-> wel_low_r;
   endproperty
   a_wel_end: assert property (p_wel_end)
      else $error("latch still set at cycle end");
   property p_busy_len;
      $fell(cycle_active_flag) |->
         busy_cnt_r == PROG_CYC || busy_cnt_r == ERASE_CYC;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy span has wrong length");
   property p_lock_upper;
      sector_lock_bits[7:2] == 6'h00;
   endproperty
   a_lock_upper: assert property (p_lock_upper)
      else $error("lock byte upper bits set");
   property p_lock_frame;
      !cs_b && $past(!cs_b) && $stable(peek_addr)
         |=> $stable(sector_lock_bits);
   endproperty
   a_lock_frame: assert property (p_lock_frame)
      else $error("lock bits changed inside a frame");
   property p_lock_busy;
      cycle_active_flag && $stable(peek_addr) |=> $stable(sector_lock_bits);
   endproperty
   a_lock_busy: assert property (p_lock_busy)
      else $error("lock bits changed while busy");
endmodule // sfpl_flash_asserts

bind sfpl_flash sfpl_flash_asserts
#(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) chk_u
(.clk, .rst_b, .cs_b, .sck, .sdi, .hw_protect, .cycle_active_flag,
 .write_enable_latch, .peek_addr, .peek_data, .sector_lock_bits);

// [test/serial_flash_program_erase_lock_tb_top.sv]
// Bench for the serial flash program, lock and erase core.
// Assumes the host model drives the pins and peeks read the array back.
`include "sfpl_map.vh"
module serial_flash_program_erase_lock_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam PB = 18'h0_1200;
   localparam PS3 = 18'h3_0500;
   logic clk, rst_b, cs_b, sck, sdi, cycle_active_flag, write_enable_latch;
   logic [1:0] hw_protect;
   logic [`SFPL_ADDR_W-1:0] peek_addr;
   logic [7:0] peek_data, sector_lock_bits;
   logic rd_v, rd_d = 1'b0;
   logic [15:0] exp_q[$];
   logic [7:0] mm[int], dq[300];
   logic [1:0] lk[4] = '{default: 2'b00};
   logic [31:0] seed = 32'h0001_481F;
   real hp = 62.5;
   int err_count, checks;

   sfpl_flash #(.PROG_CYC(400), .ERASE_CYC(600)) dut_u
   (.clk, .rst_b, .cs_b, .sck, .sdi, .hw_protect, .cycle_active_flag,
    .write_enable_latch, .peek_addr, .peek_data, .sector_lock_bits);
   sfpl_host host_u (.cs_b, .sck, .sdi);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] s, e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic peek(input logic [17:0] a);
      @(posedge clk);
      #1 peek_addr = a;
      rd_v = 1'b1;
      exp_q.push_back({6'h00, lk[a[17:16]], mm[a]});
      @(posedge clk);
      #1 rd_v = 1'b0;
   endtask

   task automatic page();
      for (int i = 0; i < 256; i++)
         peek(PB + i);
   endtask

   task automatic frame(input logic [7:0] op, input logic [17:0] a,
                        input int n, input int extra);
      host_u.q.push_back(op);
      host_u.q.push_back({6'h3F, a[17:16]});
      host_u.q.push_back(a[15:8]);
      host_u.q.push_back(a[7:0]);
      for (int i = 0; i < n; i++)
         host_u.q.push_back(dq[i]);
      host_u.send(extra, hp);
   endtask

   task automatic write_enable_cmd();
      host_u.q.push_back(`SFPL_OP_WRITE_ENABLE_CMD);
      host_u.send(0, hp);
   endtask

   task automatic prog(input logic [17:0] a, input int n, extra, bit ok);
      logic [7:0] pb[int];
      for (int k = 0; k < n; k++)
      begin
         dq[k] = rnd();
         pb[(a[7:0] + k) % 256] = dq[k];
      end
      frame(`SFPL_OP_PROG, a, n, extra);
      if (ok)
         foreach (pb[o])
            mm[{a[17:8], 8'h00} + o] &= pb[o];
   endtask

   task automatic erase(input logic [17:0] a);
      frame(`SFPL_OP_ERASE, a, 0, 0);
      for (int i = 0; i < 256; i++)
         mm[{a[17:8], 8'h00} + i] = `SFPL_ERASED;
   endtask

   task automatic lockw(input logic [7:0] d);
      write_enable_cmd();
      dq[0] = d;
      frame(`SFPL_OP_LOCK, 18'h0_ABCD, 1, 0);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 2000 && cycle_active_flag !== 1'b0; i++)
         @(posedge clk);
      check("busy", cycle_active_flag, 0);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk)
   begin
      rd_d <= rd_v;
      if (rd_d)
         check("peek", {sector_lock_bits, peek_data}, exp_q.pop_front());
   end

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #700000;
      err_count++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      rst_b = 1'b0;
      hw_protect = 2'b00;
      peek_addr = 18'h0_0000;
      rd_v = 1'b0;
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (5) @(posedge clk);
      write_enable_cmd();
      check("wel", write_enable_latch, 1);
      erase(PB | 18'h0_0037);
      check("busy", cycle_active_flag, 1);
      wait_idle();
      check("wel", write_enable_latch, 0);
      page();
      write_enable_cmd();
      prog(PB | 18'h0_00F0, 260, 0, 1);
      check("busy", cycle_active_flag, 1);
      wait_idle();
      page();
      hp = 125.0;
      write_enable_cmd();
      prog(PB | 18'h0_0010, 3, 0, 1);
      wait_idle();
      hp = 62.5;
      page();
      prog(PB, 1, 0, 0);
      check("busy", cycle_active_flag, 0);
      write_enable_cmd();
      prog(PB | 18'h0_0005, 1, 3, 0);
      check("busy", cycle_active_flag, 0);
      frame(`SFPL_OP_ERASE, PB, 0, 5);
      check("busy", cycle_active_flag, 0);
      page();
      write_enable_cmd();
      erase(PB);
      repeat (250) @(posedge clk);
      write_enable_cmd();
      prog(PB, 4, 0, 0);
      check("wel", write_enable_latch, 1);
      wait_idle();
      page();
      lockw(8'hFD);
      lk[0] = 2'b01;
      check("busy", cycle_active_flag, 0);
      check("wel", write_enable_latch, 0);
      peek(PB);
      write_enable_cmd();
      prog(PB, 1, 0, 0);
      check("busy", cycle_active_flag, 0);
      peek(PB);
      lockw(8'h03);
      lk[0] = 2'b11;
      lockw(8'h00);
      check("wel", write_enable_latch, 1);
      peek(PB);
      @(posedge clk);
      #1 rst_b = 1'b0;
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      lk[0] = 2'b00;
      repeat (5) @(posedge clk);
      check("wel", write_enable_latch, 0);
      peek(PB);
      @(posedge clk);
      #1 hw_protect = 2'b01;
      write_enable_cmd();
      frame(`SFPL_OP_ERASE, PS3, 0, 0);
      check("busy", cycle_active_flag, 0);
      prog(PS3, 1, 0, 0);
      check("busy", cycle_active_flag, 0);
      @(posedge clk);
      #1 hw_protect = 2'b10;
      frame(`SFPL_OP_ERASE, 18'h2_0100, 0, 0);
      check("busy", cycle_active_flag, 0);
      @(posedge clk);
      #1 hw_protect = 2'b11;
      frame(`SFPL_OP_ERASE, PB, 0, 0);
      check("busy", cycle_active_flag, 0);
      @(posedge clk);
      #1 hw_protect = 2'b00;
      write_enable_cmd();
      erase(PS3);
      check("busy", cycle_active_flag, 1);
      wait_idle();
      tally_and_finish();
   end
endmodule // serial_flash_program_erase_lock_tb_top
